// >>> mac_field_keystream_mask_test.sv
// Purpose: Self-checking bench for the burst keystream mask
// Assumes: Base side instance, far side in mfkm_far_model
// Notes: Random bursts from a fixed seed
`timescale 1ns/10ps
module mac_field_keystream_mask_test;
  import mfkm_pkg::*;
  // ==========================================================
  // Wiring
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic enc = 1'b0;
  logic dir = 1'b1;
  mfkm_svc_t svc = SVC_UNPROT;
  logic [8:0] cb = 9'h0;
  logic [3:0] fn = 4'h0;
  logic [23:0] mf = 24'h0;
  logic in_v = 1'b0;
  logic id = 1'b0;
  logic [1:0] mode = 2'h0;
  logic ir, ki, ks, kv, kr, kb, ov, orr;
  logic [34:0] iv;
  mfkm_bit_t ob;
  int errors = 0;
  int n_checks = 0;
  int sent = 0;
  mfkm_bit_t outq[$];
  mfkm_bit_t expq[$];
  always #5 clk = ~clk;
  mfkm_mask i_dut (
    .core_clk_i(clk),
    .reset_n_i(rst_n),
    .encrypt_i(enc),
    .tx_dir_i(dir),
    .svc_i(svc),
    .coded_bits_i(cb),
    .frame_num_i(fn),
    .multiframe_i(mf),
    .in_valid_i(in_v),
    .in_ready_o(ir),
    .in_data_i(id),
    .keystream_init_o(ki),
    .keystream_seg_o(ks),
    .init_vector_o(iv),
    .ks_valid_i(kv),
    .ks_ready_o(kr),
    .keystream_segment_i(kb),
    .out_valid_o(ov),
    .out_ready_i(orr),
    .out_o(ob)
  );
  mfkm_far_model i_far (
    .core_clk_i(clk),
    .reset_n_i(rst_n),
    .mode_i(mode),
    .keystream_init_i(ki),
    .keystream_seg_i(ks),
    .init_vector_i(iv),
    .ks_valid_o(kv),
    .ks_ready_i(kr),
    .keystream_bit_o(kb),
    .out_ready_o(orr)
  );
  always @(posedge clk) begin
    if (rst_n && ov && orr) begin
      outq.push_back(ob);
    end
  end
  // ==========================================================
  // Helpers
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Key index applied at burst position n, -1 when left clear
  function automatic int key_use(input int n, input logic [7:0] h,
                                 input mfkm_svc_t s, input int c);
    int b;
    b = n - 64;
    if (n >= 8 && n < 48) return (h[2:0] == 3'h6) ? n - 8 : -1;
    if (n < 64 || b >= 320) return -1;
    if (h[6:4] != 3'h0 || s == SVC_MULTI) return (b % 80 < 64) ? b + 40 : -1;
    if (s == SVC_SINGLE) return (b < 304) ? b + 40 : -1;
    if (s == SVC_CODED) return (b < c) ? b + 40 : -1;
    return b + 40;
  endfunction : key_use
  function automatic logic [7:0] hdr(input logic [2:0] t, input logic [2:0] m);
    return {1'($urandom), m, 1'($urandom), t};
  endfunction : hdr
  task automatic send_burst(input logic e, input logic d, input mfkm_svc_t s,
                            input int c, input logic [7:0] h);
    logic [34:0] v;
    logic b;
    logic x;
    int k;
    int w;
    int i0;
    @(negedge clk);
    enc = e;
    dir = d;
    svc = s;
    cb = 9'(c);
    fn = 4'($urandom);
    mf = 24'($urandom);
    v = {7'h0, mf, fn};
    i0 = i_far.idx;
    sent = 0;
    for (int n = 0; n < 388; n++) begin
      if (n > 0) @(negedge clk);
      b = (n < 8) ? h[n] : 1'($urandom);
      k = key_use(n, h, s, c);
      x = (e && k >= 0) ? i_far.ks_bit(v, ~d, k) : 1'b0;
      expq.push_back(mfkm_bit_t'{b ^ x, n == 387});
      in_v = 1'b1;
      id = b;
      #1;
      w = 0;
      while (!ir && w < 2000) begin
        @(negedge clk);
        #1;
        w++;
      end
      if (w == 2000) begin
        errors++;
        give_verdict();
      end
      sent++;
    end
    @(posedge clk);
    #1;
    if (e) begin
      check(64'(i_far.idx), 64'd360);
      check(64'(iv), 64'(v));
      check({63'h0, ks}, {63'h0, ~d});
    end else begin
      check(64'(i_far.idx), 64'(i0));
    end
  endtask : send_burst
  task automatic drain(input string name);
    int w;
    mfkm_bit_t g;
    w = 0;
    @(negedge clk);
    in_v = 1'b0;
    while (outq.size() < expq.size() && w < 5000) begin
      @(posedge clk);
      w++;
    end
    if (w == 5000) begin
      errors++;
      give_verdict();
    end
    check(64'(outq.size()), 64'(expq.size()));
    while (outq.size() > 0 && expq.size() > 0) begin
      g = outq.pop_front();
      check(64'(g), 64'(expq.pop_front()));
    end
    expq.delete();
    $display("test %s done", name);
  endtask : drain
  // ==========================================================
  // Tests
  initial begin
    void'($urandom(32'ha32addac));
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    send_burst(1'b0, 1'b1, SVC_SINGLE, 0, hdr(3'h6, 3'h0));
    drain("clear");
    mode = 2'h1;
    for (int i = 0; i < 4; i++) begin
      send_burst(1'b1, 1'b1, mfkm_svc_t'(4'h1 << i),
                 32 * (1 + $urandom_range(9)), hdr(3'h6, 3'h0));
    end
    drain("services");
    for (int t = 0; t < 8; t++) begin
      send_burst(1'b1, 1'b1, SVC_UNPROT, 0, hdr(3'(t), 3'h0));
    end
    drain("tails");
    for (int m = 1; m < 8; m += 3) begin
      send_burst(1'b1, 1'b1, SVC_SINGLE, 0, hdr(3'h6, 3'(m)));
    end
    drain("mux");
    for (int i = 0; i < 4; i++) begin
      send_burst(1'b1, 1'b0, mfkm_svc_t'(4'h1 << i), 96,
                 hdr(3'h6, 3'h0));
    end
    drain("receive");
    mode = 2'h2;
    fork
      send_burst(1'b1, 1'b1, SVC_MULTI, 0, hdr(3'h6, 3'h0));
    join_none
    repeat (100) @(posedge clk);
    check(64'(sent), 64'd32);
    mode = 2'h0;
    wait fork;
    drain("full");
    give_verdict();
  end
endmodule : mac_field_keystream_mask_test

// >>> mfkm_far_model.sv
// Purpose: Far side model: keystream source and channel sink
// Assumes: One 720-bit stream per frame, restarted by each init pulse
// Notes: mode 0 prompt, 1 random stalls, 2 sink blocked
`timescale 1ns/10ps
module mfkm_far_model (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [1:0] mode_i,
  input wire logic keystream_init_i,
  input wire logic keystream_seg_i,
  input wire logic [34:0] init_vector_i,
  output logic ks_valid_o = 1'b0,
  input wire logic ks_ready_i,
  output logic keystream_bit_o,
  output logic out_ready_o = 1'b0
);
  int idx = 0;
  logic last_r = 1'b0;
  // ==========================================================
  // Stream bit k of segment s, seeded by the vector
  function automatic logic ks_bit(input logic [34:0] v, input logic s,
                                  input int k);
    logic [31:0] h;
    h = v[31:0] ^ {v[34:32], 29'h0};
    h = (h + 32'(k + (s ? 360 : 0))) * 32'h9e3779b1;
    h = h ^ (h >> 15);
    return h[31] ^ h[13] ^ h[2];
  endfunction : ks_bit
  // ==========================================================
  // Segment index, restarted per frame
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idx <= 0;
    end else if (keystream_init_i) begin
      idx <= 0;
    end else if (ks_valid_o && ks_ready_i) begin
      idx <= idx + 1;
      last_r <= keystream_bit_o;
    end
  end
  // Released line shows the inverse of the last bit
  assign keystream_bit_o = ks_valid_o ?
    ks_bit(init_vector_i, keystream_seg_i, idx) : ~last_r;
  // ==========================================================
  // Stalls
  always @(negedge core_clk_i) begin
    ks_valid_o <= (mode_i != 2'h1) || ($urandom_range(3) != 0);
    out_ready_o <= (mode_i == 2'h0) ||
                   (mode_i == 2'h1 && $urandom_range(1) == 1);
  end
endmodule : mfkm_far_model

// >>> mfkm_fifo.sv
// Purpose: Bit FIFO between mask and physical channel
// Assumes: Single clock, power-of-two depth
// Notes: Output word comes from storage flops
`timescale 1ns/10ps
module mfkm_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 32
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("Depth must be a power of two");
    end
  end
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  logic full;
  logic empty;
  assign empty = (wr_r == rd_r);
  assign full = (wr_r[AW-1:0] == rd_r[AW-1:0]) && (wr_r[AW] != rd_r[AW]);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_r[rd_r[AW-1:0]];
  always_ff @(posedge core_clk_i) begin
    if (in_valid_i && !full) begin
      mem_r[wr_r[AW-1:0]] <= in_data_i;
    end
  end
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (in_valid_i && !full) begin
        wr_r <= wr_r + 1'b1;
      end
      if (out_ready_i && !empty) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end
endmodule : mfkm_fifo

// >>> mfkm_mask.sv
// Purpose: Keystream mask over a serial full-slot burst
// Assumes: One bit per cycle at most, first bit is a0
// Notes: CRC fields are formed downstream over the output
`timescale 1ns/10ps
// ==========================================================
// Contract
// - Burst is 388 bits: 64 control then 324 payload.
// - Control is 8 header, 40 tail, 16 CRC over both.
// - Payload is 320 data bits then a 4-bit CRC.
// - Tail type and payload multiplex come from header codes.
// - Multi-subfield: four subfields of 64 data plus 16 CRC.
// - Single-subfield: one 304-bit data part with 16-bit CRC.
// - Protected layout follows the negotiated service type.
// - Header and control CRC clear; tail masked only if control.
// - Payload CRC, subfield CRCs and codec redundancy stay clear.
// - Constant-size subfields: data masked, CRC bits clear.
// - Mixed multiplex payload handled as multi-subfield.
// - Source gives 2m bits per bearer pair, m is 360.
// - Key stream splits in two m-bit segments, bit 0 first.
// - Control tail: segment bits 0-39 onto a8-a47.
// - Other tail: segment bits 0-39 consumed and dropped.
// - Unprotected: segment bits 40-359 onto payload 0-319.
// - Single: bits 40-343 onto payload 0-303, rest unused.
// - Multi: four 64-bit runs masked, CRC-aligned bits unused.
// - Coded: bits 40 to 320r+39 onto payload, rest dropped.
// - Receive applies the same mapping as transmit.
// - CRCs are made and checked over the masked bits.
// - Base sends on first segment, portable on second.
// - Source reinitialised per frame with 35-bit vector.
module mfkm_mask #(
  parameter bit IS_PORTABLE = 1'b0,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic encrypt_i,
  input wire logic tx_dir_i,
  input wire mfkm_pkg::mfkm_svc_t svc_i,
  input wire logic [8:0] coded_bits_i,
  input wire logic [3:0] frame_num_i,
  input wire logic [23:0] multiframe_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic in_data_i,
  output logic keystream_init_o,
  output logic keystream_seg_o,
  output logic [34:0] init_vector_o,
  input wire logic ks_valid_i,
  output logic ks_ready_o,
  input wire logic keystream_segment_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output mfkm_pkg::mfkm_bit_t out_o
);
  import mfkm_pkg::*;
  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("FIFO too shallow");
    end
  end
  // ==========================================================
  // Burst position mapping
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } mfkm_st_t;

  function automatic logic in_ks(input logic [POS_W-1:0] p);
    in_ks = (p >= POS_W'(TAIL_POS) && p < POS_W'(CCRC_POS)) ||
            (p >= POS_W'(PAY_POS) && p < POS_W'(XCRC_POS));
  endfunction : in_ks

  function automatic logic use_ks(input logic [POS_W-1:0] p,
                                  input logic ctail,
                                  input mfkm_svc_t f,
                                  input logic [8:0] cb);
    logic [POS_W-1:0] b;
    b = p - POS_W'(PAY_POS);
    use_ks = 1'b0;
    if (p >= POS_W'(TAIL_POS) && p < POS_W'(CCRC_POS)) begin
      use_ks = ctail;
    end else if (p >= POS_W'(PAY_POS) && p < POS_W'(XCRC_POS)) begin
      unique case (f)
        SVC_UNPROT: use_ks = 1'b1;
        SVC_SINGLE: use_ks = b < POS_W'(SINGLE_DATA);
        SVC_MULTI: use_ks = (b % POS_W'(SUB_BITS)) <
                            POS_W'(SUB_DATA);
        SVC_CODED: use_ks = b < cb;
        default: use_ks = 1'b0;
      endcase
    end
  endfunction : use_ks

  mfkm_st_t st_r;
  logic [POS_W-1:0] pos_r;
  logic [HDR_BITS-1:0] hdr_r;
  logic enc_r;
  mfkm_svc_t svc_r;
  logic [8:0] cb_r;
  logic fifo_rdy;
  logic run;
  logic ctail;
  mfkm_svc_t fmt;
  logic need;
  logic apply;
  logic step;
  logic last;
  mfkm_bit_t wr_word;

  assign run = (st_r == ST_RUN);
  // Header codes pick tail type and payload layout
  assign ctail = hdr_r[TT_POS +: 3] == TT_CTRL;
  assign fmt = (hdr_r[MUX_POS +: 3] != MUX_UTYPE) ? SVC_MULTI
               : svc_r;
  assign need = enc_r && in_ks(pos_r);
  assign apply = need && use_ks(pos_r, ctail, fmt, cb_r);
  assign step = run && in_valid_i && fifo_rdy && (!need || ks_valid_i);
  assign last = pos_r == POS_W'(BURST_BITS - 1);
  assign in_ready_o = run && fifo_rdy && (!need || ks_valid_i);
  assign ks_ready_o = run && in_valid_i && fifo_rdy && need;
  // Same mapping serves transmit and receive
  assign wr_word.data = in_data_i ^ (apply & keystream_segment_i);
  assign wr_word.last = last;

  // ==========================================================
  // Burst sequencing
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= ST_IDLE;
      pos_r <= '0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          pos_r <= '0;
          if (in_valid_i) begin
            st_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (step) begin
            pos_r <= last ? '0 : pos_r + 1'b1;
            if (last) begin
              st_r <= ST_IDLE;
            end
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Header capture, a0 first
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hdr_r <= '0;
    end else if (step && pos_r < POS_W'(HDR_BITS)) begin
      hdr_r[pos_r[2:0]] <= in_data_i;
    end
  end

  // Mode latched per burst
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      enc_r <= 1'b0;
      svc_r <= SVC_UNPROT;
      cb_r <= '0;
    end else if (st_r == ST_IDLE && in_valid_i) begin
      enc_r <= encrypt_i;
      svc_r <= svc_i;
      cb_r <= coded_bits_i;
    end
  end

  // Keystream source start per encrypted burst
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      keystream_init_o <= 1'b0;
      keystream_seg_o <= 1'b0;
      init_vector_o <= '0;
    end else begin
      keystream_init_o <= st_r == ST_IDLE && in_valid_i && encrypt_i;
      if (st_r == ST_IDLE && in_valid_i) begin
        keystream_seg_o <= IS_PORTABLE ~^ tx_dir_i;
        init_vector_o <= {IV_PAD'(0), multiframe_i,
                          frame_num_i};
      end
    end
  end

  // ==========================================================
  // Output buffer; CRC units sit after it
  mfkm_fifo #(
    .WIDTH($bits(mfkm_bit_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(step),
    .in_ready_o(fifo_rdy),
    .in_data_i(wr_word),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_data_o(out_o)
  );

  // ==========================================================
  // Checks
  logic [POS_W-1:0] ks_cnt_r;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ks_cnt_r <= '0;
    end else if (st_r == ST_IDLE) begin
      ks_cnt_r <= '0;
    end else if (ks_ready_o && ks_valid_i) begin
      ks_cnt_r <= ks_cnt_r + 1'b1;
    end
  end

  hdr_clear_a: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    step && (pos_r < POS_W'(TAIL_POS) ||
    (pos_r >= POS_W'(CCRC_POS) && pos_r < POS_W'(PAY_POS)))
    |-> wr_word.data == in_data_i)
    else $error("Header or control CRC altered");

  ks_idle_a: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    !enc_r |-> !ks_ready_o && wr_word.data == in_data_i)
    else $error("Keystream used outside encrypt mode");

  seg_count_a: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    step && last |=> ks_cnt_r == (enc_r ? POS_W'(SEG_BITS) : '0))
    else $error("Segment bit count wrong");

  xcrc_clear_a: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    step && pos_r >= POS_W'(XCRC_POS) |-> wr_word.data == in_data_i)
    else $error("Payload CRC altered");

  sub_crc_a: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    step && fmt == SVC_MULTI && pos_r >= POS_W'(PAY_POS) &&
    ((pos_r - POS_W'(PAY_POS)) % POS_W'(SUB_BITS)) >= POS_W'(SUB_DATA)
    |-> wr_word.data == in_data_i)
    else $error("Subfield CRC altered");

  tail_xor_a: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    step && enc_r && ctail && pos_r >= POS_W'(TAIL_POS) &&
    pos_r < POS_W'(CCRC_POS)
    |-> wr_word.data == (in_data_i ^ keystream_segment_i) &&
    ks_cnt_r == pos_r - POS_W'(TAIL_POS))
    else $error("Control tail not masked");

  tail_drop_a: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    step && enc_r && !ctail && pos_r >= POS_W'(TAIL_POS) &&
    pos_r < POS_W'(CCRC_POS) |-> ks_ready_o && wr_word.data == in_data_i)
    else $error("Other tail not passed clear");

  single_tail_a: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    step && fmt == SVC_SINGLE &&
    pos_r >= POS_W'(PAY_POS + SINGLE_DATA) |-> wr_word.data == in_data_i)
    else $error("Single subfield CRC altered");

  init_vec_a: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    keystream_init_o |-> init_vector_o ==
    {IV_PAD'(0), $past(multiframe_i), $past(frame_num_i)} && run)
    else $error("Init vector wrong");

  seg_pick_a: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    keystream_init_o |-> keystream_seg_o == (IS_PORTABLE ^ !$past(tx_dir_i)))
    else $error("Wrong segment chosen");

  burst_len_a: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    step |-> wr_word.last == (pos_r == POS_W'(BURST_BITS - 1)))
    else $error("Burst end misplaced");

  enc_burst_c: cover property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    step && last && enc_r);
  ctl_tail_c: cover property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    step && enc_r && ctail);
  coded_c: cover property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    step && fmt == SVC_CODED && apply);
  stall_c: cover property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    run && in_valid_i && !fifo_rdy);
endmodule : mfkm_mask

// >>> mfkm_pkg.sv
// Purpose: Constants and types for the burst keystream mask
// Assumes: Full slot, 2-level modulation, serial burst bits
// Notes: Header code values are local encodings
package mfkm_pkg;
  // ==========================================================
  // Burst layout
  localparam int HDR_BITS = 8;
  localparam int TAIL_BITS = 40;
  localparam int CCRC_BITS = 16;
  localparam int CTRL_BITS = HDR_BITS + TAIL_BITS + CCRC_BITS;
  localparam int DATA_BITS = 320;
  localparam int XCRC_BITS = 4;
  localparam int PAY_BITS = DATA_BITS + XCRC_BITS;
  localparam int BURST_BITS = CTRL_BITS + PAY_BITS;
  localparam int TAIL_POS = HDR_BITS;
  localparam int CCRC_POS = TAIL_POS + TAIL_BITS;
  localparam int PAY_POS = CTRL_BITS;
  localparam int XCRC_POS = PAY_POS + DATA_BITS;
  localparam int SUB_DATA = 64;
  localparam int SUB_CRC = 16;
  localparam int SUB_BITS = SUB_DATA + SUB_CRC;
  localparam int SINGLE_DATA = 304;
  localparam int SEG_BITS = TAIL_BITS + DATA_BITS;
  // ==========================================================
  // Header codes
  localparam int TT_POS = 0;
  localparam int MUX_POS = 4;
  localparam logic [2:0] TT_CTRL = 3'h6;
  localparam logic [2:0] MUX_UTYPE = 3'h0;
  // ==========================================================
  // Init vector
  localparam int IV_BITS = 35;
  localparam int FN_BITS = 4;
  localparam int MFN_BITS = 24;
  localparam int IV_PAD = IV_BITS - FN_BITS - MFN_BITS;
  localparam int POS_W = 9;
  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    SVC_UNPROT = 4'h1,
    SVC_MULTI = 4'h2,
    SVC_SINGLE = 4'h4,
    SVC_CODED = 4'h8
  } mfkm_svc_t;
  typedef struct packed {
    logic data;
    logic last;
  } mfkm_bit_t;
endpackage : mfkm_pkg
